//--- verilog/cgr_pkg.sv
// Package for the CPU general register file: sizes, views, reset values and timing counts.
// Assumes a single core clock at 100 MHz shared by decoder, datapath and this block.
package cgr_pkg;
  localparam int          NUM_REGS      = 8;
  localparam int          REG_W         = 32;
  localparam int          IDX_W         = 3;
  localparam int          PC_W          = 24;
  localparam int          CCR_W         = 8;
  localparam int          ADDR_SPACE_W  = 16;
  localparam int          CCR_IMASK_BIT = 7;
  localparam logic [7:0]  CCR_RST       = 8'h80;
  localparam logic [23:0] PC_RST        = 24'h000000;
  localparam int          SP_IDX        = 7;
  localparam int          CLK_MHZ       = 100;
  localparam int          ADDSUB_STATES = 2;
  localparam int          MULDIV8_STATES  = 14;
  localparam int          MULDIV16_STATES = 22;

  typedef enum logic [1:0] {
    CGR_W8,
    CGR_W16,
    CGR_W32
  } cgr_width_t;

  typedef enum logic [1:0] {
    CGR_OP_ADD,
    CGR_OP_SUB,
    CGR_OP_MUL,
    CGR_OP_DIV
  } cgr_op_t;
endpackage

//--- verilog/cgr_regfile.sv
// CPU general register file with program counter, condition flags and a register-register ALU timer.
// Assumes the decoder holds its request fields stable for the cycle a strobe is high.
`timescale 1ns/1ps

module cgr_regfile #(
  parameter int ADDSUB_N   = cgr_pkg::ADDSUB_STATES,
  parameter int MULDIV8_N  = cgr_pkg::MULDIV8_STATES,
  parameter int MULDIV16_N = cgr_pkg::MULDIV16_STATES
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [2:0]           rd_a_idx_i,
  input  wire cgr_pkg::cgr_width_t  rd_a_width_i,
  input  wire logic                 rd_a_ext_i,
  input  wire logic                 rd_a_high_i,
  input  wire logic [2:0]           rd_b_idx_i,
  input  wire cgr_pkg::cgr_width_t  rd_b_width_i,
  input  wire logic                 rd_b_ext_i,
  input  wire logic                 rd_b_high_i,
  input  wire logic                 wr_en_i,
  input  wire logic [2:0]           wr_idx_i,
  input  wire cgr_pkg::cgr_width_t  wr_width_i,
  input  wire logic                 wr_ext_i,
  input  wire logic                 wr_high_i,
  input  wire logic [31:0]          wr_data_i,
  input  wire logic                 sp_wr_en_i,
  input  wire logic [31:0]          sp_wr_data_i,
  input  wire logic                 pc_ld_i,
  input  wire logic [23:0]          pc_ld_data_i,
  input  wire logic                 pc_inc_i,
  input  wire logic                 vec_ld_i,
  input  wire logic [23:0]          vec_data_i,
  input  wire logic                 ccr_wr_en_i,
  input  wire logic [7:0]           ccr_wr_data_i,
  input  wire logic                 exc_entry_i,
  input  wire logic                 sleep_i,
  input  wire logic                 wake_i,
  input  wire logic                 alu_start_i,
  input  wire cgr_pkg::cgr_op_t     alu_op_i,
  input  wire cgr_pkg::cgr_width_t  alu_width_i,
  output logic [31:0]               rd_a_data_o,
  output logic [15:0]               rd_a_addr_o,
  output logic [31:0]               rd_b_data_o,
  output logic [31:0]               sp_o,
  output logic [23:0]               pc_o,
  output logic [23:0]               fetch_addr_o,
  output logic [7:0]                ccr_o,
  output logic                      power_down_o,
  output logic                      alu_busy_o,
  output logic                      alu_done_o
);
  import cgr_pkg::*;

  localparam int ADDSUB_WAIT   = ADDSUB_N - 2;
  localparam int MULDIV8_WAIT  = MULDIV8_N - 2;
  localparam int MULDIV16_WAIT = MULDIV16_N - 2;

  // The five-bit timer serves counts from two to thirty-one only.
  if (ADDSUB_N < 2 || ADDSUB_N > 31 || MULDIV8_N < 2 || MULDIV8_N > 31 ||
      MULDIV16_N < 2 || MULDIV16_N > 31) begin : g_count_check
    $error("ALU state count outside two to thirty-one");
  end

  typedef struct packed {
    logic [NUM_REGS-1:0][REG_W-1:0] gr;
    logic [31:0]                    rd_a;
    logic [15:0]                    rd_a_addr;
    logic [31:0]                    rd_b;
    logic [PC_W-1:0]                pc;
    logic [CCR_W-1:0]               condition_flags_register;
    logic                           pdown;
    logic [4:0]                     alu_cnt;
    logic                           alu_busy;
    logic                           alu_done;
  } cgr_state_t;

  cgr_state_t s_q;
  cgr_state_t s_d;

  function automatic logic [31:0] view_read(input logic [31:0] r, input cgr_width_t w,
                                            input logic ext, input logic high);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (w)
      CGR_W32: v = r;
      CGR_W16: v = {16'h0000, ext ? r[31:16] : r[15:0]};
      CGR_W8:  v = {24'h000000, high ? r[15:8] : r[7:0]};
      default: v = r;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] view_write(input logic [31:0] r, input cgr_width_t w,
                                             input logic ext, input logic high, input logic [31:0] d);
    logic [31:0] v;
    v = r;
    unique case (w)
      CGR_W32: v = d;
      CGR_W16: if (ext) v[31:16] = d[15:0]; else v[15:0] = d[15:0];
      CGR_W8:  if (high) v[15:8] = d[7:0]; else v[7:0] = d[7:0];
      default: v = d;
    endcase
    return v;
  endfunction

  function automatic logic [4:0] alu_states(input cgr_op_t op, input cgr_width_t w);
    logic [4:0] n;
    n = 5'(ADDSUB_N);
    if (op == CGR_OP_MUL || op == CGR_OP_DIV) begin
      n = (w == CGR_W8) ? 5'(MULDIV8_N) : 5'(MULDIV16_N);
    end
    return n;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.alu_done = 1'b0;
    // Operands are registered so both appear one edge after the select.
    s_d.rd_a = view_read(s_q.gr[rd_a_idx_i], rd_a_width_i, rd_a_ext_i, rd_a_high_i);
    s_d.rd_a_addr = s_q.gr[rd_a_idx_i][ADDR_SPACE_W-1:0];
    s_d.rd_b = view_read(s_q.gr[rd_b_idx_i], rd_b_width_i, rd_b_ext_i, rd_b_high_i);
    if (wr_en_i) begin
      s_d.gr[wr_idx_i] = view_write(s_q.gr[wr_idx_i], wr_width_i, wr_ext_i, wr_high_i, wr_data_i);
    end
    // Implicit stack updates take priority over a datapath write to the same register.
    if (sp_wr_en_i) begin
      s_d.gr[SP_IDX] = sp_wr_data_i;
    end
    if (vec_ld_i) begin
      s_d.pc = vec_data_i;
    end else if (pc_ld_i) begin
      s_d.pc = pc_ld_data_i;
    end else if (pc_inc_i) begin
      s_d.pc = PC_W'(s_q.pc + 24'h000002);
    end
    if (ccr_wr_en_i) begin
      s_d.condition_flags_register = ccr_wr_data_i;
    end
    if (exc_entry_i) begin
      s_d.condition_flags_register[CCR_IMASK_BIT] = 1'b1;
    end
    if (wake_i) begin
      s_d.pdown = 1'b0;
    end else if (sleep_i) begin
      s_d.pdown = 1'b1;
    end
    if (s_q.alu_busy) begin
      s_d.alu_cnt = 5'(s_q.alu_cnt - 5'h01);
      if (s_q.alu_cnt == 5'h01) begin
        s_d.alu_busy = 1'b0;
        s_d.alu_done = 1'b1;
      end
    end else if (alu_start_i) begin
      s_d.alu_busy = 1'b1;
      s_d.alu_cnt = 5'(alu_states(alu_op_i, alu_width_i) - 5'h01);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.pc <= PC_RST;
      s_q.condition_flags_register <= CCR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_a_data_o  = s_q.rd_a;
  assign rd_a_addr_o  = s_q.rd_a_addr;
  assign rd_b_data_o  = s_q.rd_b;
  assign sp_o         = s_q.gr[SP_IDX];
  assign pc_o         = s_q.pc;
  assign fetch_addr_o = {s_q.pc[PC_W-1:1], 1'b0};
  assign ccr_o        = s_q.condition_flags_register;
  assign power_down_o = s_q.pdown;
  assign alu_busy_o   = s_q.alu_busy;
  assign alu_done_o   = s_q.alu_done;

  // Assertions.
  property p_fetch_even;
    @(posedge core_clk_i) disable iff (!rst_n_i) fetch_addr_o[0] == 1'b0;
  endproperty
  a_fetch_even: assert property (p_fetch_even) else $error("fetch address odd");

  property p_vec_load;
    @(posedge core_clk_i) disable iff (!rst_n_i) vec_ld_i |=> pc_o == $past(vec_data_i);
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("vector not loaded");

  property p_addsub_time;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (alu_start_i && !alu_busy_o && (alu_op_i == CGR_OP_ADD || alu_op_i == CGR_OP_SUB))
      |=> alu_busy_o ##ADDSUB_WAIT (alu_busy_o && !alu_done_o) ##1 alu_done_o;
  endproperty
  a_addsub_time: assert property (p_addsub_time) else $error("add or sub not 2 cycles");

  property p_muldiv8_time;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (alu_start_i && !alu_busy_o && alu_op_i inside {CGR_OP_MUL, CGR_OP_DIV} && alu_width_i == CGR_W8)
      |=> alu_busy_o ##MULDIV8_WAIT (alu_busy_o && !alu_done_o) ##1 alu_done_o;
  endproperty
  a_muldiv8_time: assert property (p_muldiv8_time) else $error("small mul or div not 14 cycles");

  property p_muldiv16_time;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (alu_start_i && !alu_busy_o && alu_op_i inside {CGR_OP_MUL, CGR_OP_DIV} && alu_width_i != CGR_W8)
      |=> alu_busy_o ##MULDIV16_WAIT (alu_busy_o && !alu_done_o) ##1 alu_done_o;
  endproperty
  a_muldiv16_time: assert property (p_muldiv16_time) else $error("wide mul or div not 22 cycles");

  property p_byte_keep;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_en_i && !sp_wr_en_i && wr_width_i == CGR_W8 && !wr_high_i)
      |=> s_q.gr[$past(wr_idx_i)][31:8] == $past(s_q.gr[wr_idx_i][31:8])
          && s_q.gr[$past(wr_idx_i)][7:0] == $past(wr_data_i[7:0]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("byte write disturbed other bits");

  property p_half_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_a_width_i == CGR_W16 && rd_a_ext_i)
      |=> rd_a_data_o == {16'h0000, $past(s_q.gr[rd_a_idx_i][31:16])};
  endproperty
  a_half_read: assert property (p_half_read) else $error("extended half read wrong");

  property p_sleep;
    @(posedge core_clk_i) disable iff (!rst_n_i) (sleep_i && !wake_i) |=> power_down_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("power-down not entered");

  property p_exc_mask;
    @(posedge core_clk_i) disable iff (!rst_n_i) exc_entry_i |=> ccr_o[CCR_IMASK_BIT];
  endproperty
  a_exc_mask: assert property (p_exc_mask) else $error("interrupt mask not set");

  property p_sp_write;
    @(posedge core_clk_i) disable iff (!rst_n_i) sp_wr_en_i |=> sp_o == $past(sp_wr_data_i);
  endproperty
  a_sp_write: assert property (p_sp_write) else $error("stack pointer not written");

  property p_wide_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_en_i && wr_width_i == CGR_W32 && !(sp_wr_en_i && wr_idx_i == 3'(SP_IDX)))
      |=> s_q.gr[$past(wr_idx_i)] == $past(wr_data_i);
  endproperty
  a_wide_write: assert property (p_wide_write) else $error("wide write not stored");

  property p_high_keep;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_en_i && !sp_wr_en_i && wr_width_i == CGR_W8 && wr_high_i)
      |=> s_q.gr[$past(wr_idx_i)] == {$past(s_q.gr[wr_idx_i][31:16]), $past(wr_data_i[7:0]),
                                     $past(s_q.gr[wr_idx_i][7:0])};
  endproperty
  a_high_keep: assert property (p_high_keep) else $error("high byte write disturbed other bits");

  property p_ext_keep;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_en_i && !sp_wr_en_i && wr_width_i == CGR_W16 && wr_ext_i)
      |=> s_q.gr[$past(wr_idx_i)] == {$past(wr_data_i[15:0]), $past(s_q.gr[wr_idx_i][15:0])};
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("extended half write disturbed base half");

  property p_addr_view;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1 |=> rd_a_addr_o == $past(s_q.gr[rd_a_idx_i][ADDR_SPACE_W-1:0]);
  endproperty
  a_addr_view: assert property (p_addr_view) else $error("address view wrong");

  property p_wide_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_a_width_i == CGR_W32)
      |=> rd_a_data_o == $past(s_q.gr[rd_a_idx_i]);
  endproperty
  a_wide_read: assert property (p_wide_read) else $error("wide read wrong");

  property p_byte_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_a_width_i == CGR_W8 && rd_a_high_i)
      |=> rd_a_data_o == {24'h000000, $past(s_q.gr[rd_a_idx_i][15:8])};
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("high byte read wrong");

  property p_b_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_b_width_i == CGR_W16 && rd_b_ext_i)
      |=> rd_b_data_o == {16'h0000, $past(s_q.gr[rd_b_idx_i][31:16])};
  endproperty
  a_b_read: assert property (p_b_read) else $error("second port half read wrong");

  property p_pc_load;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (pc_ld_i && !vec_ld_i) |=> pc_o == $past(pc_ld_data_i);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("program counter not loaded");

  property p_pc_step;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (pc_inc_i && !pc_ld_i && !vec_ld_i)
      |=> pc_o == PC_W'($past(pc_o) + 24'h000002);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("program counter step not one word");

  property p_pc_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (!pc_inc_i && !pc_ld_i && !vec_ld_i) |=> $stable(pc_o);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("program counter moved unasked");

  property p_ccr_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ccr_wr_en_i && !exc_entry_i) |=> ccr_o == $past(ccr_wr_data_i);
  endproperty
  a_ccr_write: assert property (p_ccr_write) else $error("condition flags not written");

  property p_wake;
    @(posedge core_clk_i) disable iff (!rst_n_i) wake_i |=> !power_down_o;
  endproperty
  a_wake: assert property (p_wake) else $error("power-down not left");

  property p_done_pulse;
    @(posedge core_clk_i) disable iff (!rst_n_i) alu_done_o |=> !alu_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_count_step;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (alu_busy_o && s_q.alu_cnt != 5'h01)
      |=> alu_busy_o && s_q.alu_cnt == 5'($past(s_q.alu_cnt) - 5'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("timer disturbed while busy");
endmodule

//--- tb/cgr_dp_model.sv
// Datapath-side model that issues ALU requests and times their completion.
// Assumes it shares the register file's core clock.
`timescale 1ns/1ps
module cgr_dp_model
  import cgr_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         busy_i,
  input  wire logic         done_i,
  output logic              start_o,
  output cgr_pkg::cgr_op_t  op_o,
  output cgr_pkg::cgr_width_t width_o
);
  initial begin
    start_o = 1'h0;
    op_o    = CGR_OP_ADD;
    width_o = CGR_W8;
  end

  // Sends one start pulse, counts edges from the start edge to the one sampling done, and busy cycles.
  task automatic run(input cgr_op_t op, input cgr_width_t w, output int n, output int nb);
    @(posedge clk_i);
    start_o <= 1'h1;
    op_o    <= op;
    width_o <= w;
    @(posedge clk_i);
    start_o <= 1'h0;
    n = 1;
    #1;
    nb = (busy_i === 1'h1) ? 1 : 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      if (busy_i === 1'h1) nb++;
    end while (done_i !== 1'h1 && n < 40);
  endtask
endmodule

//--- tb/cgr_regfile_test.sv
// Self-checking bench for the register file, one task per scenario.
// Assumes the datapath model drives the ALU request inputs.
`timescale 1ns/1ps
module cgr_regfile_test;
  import cgr_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0, w_en = 1'h0, w_ext = 1'h0, w_hi = 1'h0;
  logic        a_ext = 1'h0, a_hi = 1'h0, b_ext = 1'h0, b_hi = 1'h0, pd, busy, done, start;
  logic [2:0]  a_idx = '0, b_idx = '0, w_idx = '0;
  cgr_width_t  a_w = CGR_W32, b_w = CGR_W32, w_w = CGR_W32, aw;
  cgr_op_t     op;
  logic [7:0]  pls = '0, condition_flags_register;
  logic [31:0] w_dat = '0, pdat = '0, a_dat, b_dat, sp;
  logic [23:0] pc, fa;
  logic [15:0] a_addr;
  int          mismatches = 0, tests_run = 0, cycles = 0, n, nb;

  always #5 clk = ~clk;

  cgr_regfile i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .rd_a_idx_i(a_idx), .rd_a_width_i(a_w),
    .rd_a_ext_i(a_ext), .rd_a_high_i(a_hi), .rd_b_idx_i(b_idx), .rd_b_width_i(b_w), .rd_b_ext_i(b_ext),
    .rd_b_high_i(b_hi), .wr_en_i(w_en), .wr_idx_i(w_idx), .wr_width_i(w_w), .wr_ext_i(w_ext),
    .wr_high_i(w_hi), .wr_data_i(w_dat), .sp_wr_en_i(pls[0]), .sp_wr_data_i(pdat), .pc_ld_i(pls[1]),
    .pc_ld_data_i(pdat[23:0]), .pc_inc_i(pls[2]), .vec_ld_i(pls[3]), .vec_data_i(pdat[23:0]),
    .ccr_wr_en_i(pls[4]), .ccr_wr_data_i(pdat[7:0]), .exc_entry_i(pls[5]), .sleep_i(pls[6]),
    .wake_i(pls[7]), .alu_start_i(start), .alu_op_i(op), .alu_width_i(aw), .rd_a_data_o(a_dat),
    .rd_a_addr_o(a_addr), .rd_b_data_o(b_dat), .sp_o(sp), .pc_o(pc), .fetch_addr_o(fa), .ccr_o(condition_flags_register),
    .power_down_o(pd), .alu_busy_o(busy), .alu_done_o(done));

  cgr_dp_model i_dp (.clk_i(clk), .busy_i(busy), .done_i(done), .start_o(start), .op_o(op), .width_o(aw));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic wr(input logic [2:0] i, input cgr_width_t w, input logic e, h, input logic [31:0] d);
    @(posedge clk);
    w_en  <= 1'h1;
    w_idx <= i;
    w_w   <= w;
    w_ext <= e;
    w_hi  <= h;
    w_dat <= d;
    @(posedge clk);
    w_en <= 1'h0;
  endtask

  task automatic rd(input logic [2:0] i, input cgr_width_t w, input logic e, h);
    @(posedge clk);
    a_idx <= i;
    a_w   <= w;
    a_ext <= e;
    a_hi  <= h;
    @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int k, input logic [31:0] d);
    @(posedge clk);
    pls[k] <= 1'h1;
    pdat   <= d;
    @(posedge clk);
    pls <= '0;
    #1;
  endtask

  task automatic t_reset();
    check(condition_flags_register, 32'h80);
    check(pc, 32'h0);
    check(pd, 32'h0);
  endtask

  task automatic t_wide();
    for (int i = 0; i < 8; i++) wr(3'(i), CGR_W32, 1'h0, 1'h0, 32'h87654320 + 32'(i));
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), CGR_W32, 1'h0, 1'h0);
      check(a_dat, 32'h87654320 + 32'(i));
      check(a_addr, 32'h4320 + 32'(i));
    end
  endtask

  task automatic t_narrow();
    wr(3'h2, CGR_W8, 1'h0, 1'h0, 32'h11);
    wr(3'h2, CGR_W8, 1'h0, 1'h1, 32'h22);
    wr(3'h2, CGR_W16, 1'h1, 1'h0, 32'h3344);
    rd(3'h2, CGR_W32, 1'h0, 1'h0);
    check(a_dat, 32'h33442211);
    @(posedge clk);
    b_idx <= 3'h2;
    b_w   <= CGR_W16;
    b_ext <= 1'h1;
    rd(3'h2, CGR_W8, 1'h0, 1'h1);
    check(a_dat, 32'h22);
    check(b_dat, 32'h3344);
    rd(3'h2, CGR_W16, 1'h0, 1'h0);
    check(a_dat, 32'h2211);
  endtask

  task automatic t_ctrl();
    pulse(0, 32'h0000fffe);
    check(sp, 32'h0000fffe);
    rd(3'h7, CGR_W32, 1'h0, 1'h0);
    check(a_dat, 32'h0000fffe);
    pulse(3, 32'h012345);
    check(pc, 32'h012345);
    check(fa, 32'h012344);
    pulse(2, 32'h0);
    check(pc, 32'h012347);
    pulse(1, 32'hfffffe);
    pulse(2, 32'h0);
    check(pc, 32'h0);
    pulse(4, 32'h3c);
    check(condition_flags_register, 32'h3c);
    pulse(5, 32'h0);
    check(condition_flags_register, 32'hbc);
    pulse(6, 32'h0);
    check(pd, 32'h1);
    pulse(7, 32'h0);
    check(pd, 32'h0);
  endtask

  task automatic t_rerun();
    pulse(1, 32'h000100);
    check(pc, 32'h100);
    pulse(6, 32'h0);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    #1;
    t_reset();
    check(sp, 32'h0);
  endtask

  task automatic t_alu();
    int e;
    for (int k = 0; k < 8; k++) begin
      e = (k < 4) ? 2 : ((k % 2) ? 22 : 14);
      i_dp.run(cgr_op_t'(k / 2), (k % 2) ? CGR_W16 : CGR_W8, n, nb);
      check(n, e);
      check(nb, e - 1);
    end
    i_dp.run(CGR_OP_MUL, CGR_W32, n, nb);
    check(n, 32'h16);
    check(nb, 32'h15);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    #1;
    t_reset();
    t_wide();
    t_narrow();
    t_ctrl();
    t_rerun();
    t_alu();
    final_report();
  end
endmodule
